// >>> src/rtc_ctl_regs.svh
// register offsets, fields, reset values for the clock front end
`ifndef RTC_CTL_REGS_SVH
`define RTC_CTL_REGS_SVH
`define RTC_ADDR_W 7
`define RTC_REG_A 7'h0a
`define RTC_REG_B 7'h0b
`define RTC_REG_C 7'h0c
`define RTC_REG_D 7'h0d
`define RTC_STAT 7'h7e
`define RTC_MASK 7'h7f
`define RTC_B_SQW 3
`define RTC_B_UIE 4
`define RTC_B_AIE 5
`define RTC_B_PIE 6
`define RTC_C_UF 4
`define RTC_C_AF 5
`define RTC_C_PF 6
`define RTC_C_SUMMARY_REQUEST_FLAG 7
`define RTC_D_VRT 7
`define RTC_REG_RESET 8'h00
`define RTC_EV_W 3
`define RTC_EV_PF 0
`define RTC_EV_AF 1
`define RTC_EV_UF 2
`endif

// >>> src/rtc_ctl_pkg.sv
// types for the clock front end
package rtc_ctl_pkg;
	typedef enum logic {acc_read, acc_write} acc_kind_t;
endpackage : rtc_ctl_pkg

// >>> src/rtc_ram.sv
// small byte memory for the general purpose ram bytes
`timescale 1ns/10ps
module rtc_ram #(
	parameter int ADDR_W = 7,
	parameter int DATA_W = 8
) (
	// clock
	input wire logic sys_clk,
	// access
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] wr_data,
	output logic [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[addr] <= wr_data;
		end
		rd_data <= mem[addr];
	end
endmodule : rtc_ram

// >>> src/rtc_bus_power_control.sv
// power and bus front end control of the real time clock section
// What this block does
// - address on the multiplexed bus is captured at the strobe's falling edge
// - restore strobe low with test low clears the three interrupt enables
// - restore strobe low with test low clears all four interrupt flags
// - restore strobe low with test low clears the square-wave enable
// - restore strobe low with test low blocks all pin bus reads and writes; the register port still works
// - power good low makes the block ignore address, data and strobes
//
// The implementer's own choices: strobed register access and the register addresses.
`timescale 1ns/10ps
`include "rtc_ctl_regs.svh"
module rtc_bus_power_control #(
	parameter int ADDR_W = `RTC_ADDR_W
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// pins
	input wire logic address_latch_strobe,
	input wire logic [7:0] multiplexed_data_bus,
	input wire logic data_read_strobe,
	input wire logic data_write_strobe,
	input wire logic supply_restore_strobe_n,
	input wire logic power_good_in,
	input wire logic test_in,
	// data answer
	output logic [7:0] data_out,
	output logic data_out_en,
	// clock core events
	input wire logic [`RTC_EV_W-1:0] core_event,
	// control outputs
	output logic periodic_irq_enable,
	output logic alarm_irq_enable,
	output logic update_done_irq_enable,
	output logic square_wave_enable,
	output logic irq_n,
	// register port
	input wire logic [6:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	output logic irq
);
	logic strobe_q;
	logic [ADDR_W-1:0] latched_addr;
	logic [7:0] reg_a;
	logic [7:0] reg_b;
	logic update_done_flag;
	logic periodic_flag;
	logic alarm_flag;
	logic summary_request_flag;
	logic [`RTC_EV_W-1:0] stat;
	logic [`RTC_EV_W-1:0] mask;
	rtc_ctl_pkg::acc_kind_t last_kind;

	// power gating and restore condition
	wire restore_hold = !supply_restore_strobe_n && !test_in;
	wire pins_live = power_good_in && !restore_hold;
	wire strobe_fall = strobe_q && !address_latch_strobe;
	// ram sees the new address at the latching edge, so a read right after the strobe gets the right byte
	wire [ADDR_W-1:0] next_latched = (strobe_fall && pins_live) ? multiplexed_data_bus[ADDR_W-1:0] :
		latched_addr;
	wire bus_wr = pins_live && data_write_strobe;
	wire bus_rd = pins_live && data_read_strobe;
	wire sel_a = latched_addr == `RTC_REG_A;
	wire sel_b = latched_addr == `RTC_REG_B;
	wire sel_c = latched_addr == `RTC_REG_C;
	wire sel_d = latched_addr == `RTC_REG_D;
	wire sel_ram = !(sel_a || sel_b || sel_c || sel_d);
	wire ram_wr = bus_wr && sel_ram;
	wire [7:0] ram_rdata;
	wire [7:0] reg_c = {summary_request_flag, periodic_flag, alarm_flag, update_done_flag, 4'h0};
	wire [`RTC_EV_W-1:0] flags_en = {update_done_irq_enable, alarm_irq_enable, periodic_irq_enable};
	wire [`RTC_EV_W-1:0] flags_now = {update_done_flag, alarm_flag, periodic_flag};
	wire next_summary = |(flags_en & flags_now);
	wire clear_c = bus_rd && sel_c;
	wire [7:0] pin_rdata = sel_a ? reg_a : sel_b ? reg_b : sel_c ? reg_c :
		sel_d ? 8'h80 : ram_rdata;
	wire stat_wr = reg_wr && reg_addr == `RTC_STAT;
	wire mask_wr = reg_wr && reg_addr == `RTC_MASK;
	wire [`RTC_EV_W-1:0] next_mask = mask_wr ? reg_wdata[`RTC_EV_W-1:0] : mask;
	wire [`RTC_EV_W-1:0] next_stat = (stat & ~(stat_wr ? reg_wdata[`RTC_EV_W-1:0] : '0)) | core_event;
	wire [7:0] next_reg_rdata = reg_addr == `RTC_STAT ? {5'h00, stat} :
		reg_addr == `RTC_MASK ? {5'h00, mask} :
		reg_addr == `RTC_REG_B ? reg_b : reg_addr == `RTC_REG_C ? reg_c : 8'h00;

	rtc_ram #(
		.ADDR_W(ADDR_W),
		.DATA_W(8)
	) u_ram (
		.sys_clk(sys_clk),
		.wr_en(ram_wr),
		.addr(next_latched),
		.wr_data(multiplexed_data_bus),
		.rd_data(ram_rdata)
	);

	// address capture at falling edge of strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			strobe_q <= 1'b0;
			latched_addr <= '0;
		end else begin
			strobe_q <= address_latch_strobe && pins_live;
			if (strobe_fall && pins_live) begin
				latched_addr <= multiplexed_data_bus[ADDR_W-1:0];
			end
		end
	end

	// control register b and a
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			reg_a <= `RTC_REG_RESET;
			reg_b <= `RTC_REG_RESET;
		end else if (restore_hold) begin
			reg_b[`RTC_B_PIE] <= 1'b0;
			reg_b[`RTC_B_AIE] <= 1'b0;
			reg_b[`RTC_B_UIE] <= 1'b0;
			reg_b[`RTC_B_SQW] <= 1'b0;
		end else if (bus_wr && sel_a) begin
			reg_a <= multiplexed_data_bus;
		end else if (bus_wr && sel_b) begin
			reg_b <= multiplexed_data_bus;
		end
	end

	// interrupt flags; event beats the read clear, except for the summary flag
	always_ff @(posedge sys_clk) begin
		if (sys_rst || restore_hold) begin
			update_done_flag <= 1'b0;
			periodic_flag <= 1'b0;
			alarm_flag <= 1'b0;
			summary_request_flag <= 1'b0;
		end else begin
			update_done_flag <= core_event[`RTC_EV_UF] || (update_done_flag && !clear_c);
			periodic_flag <= core_event[`RTC_EV_PF] || (periodic_flag && !clear_c);
			alarm_flag <= core_event[`RTC_EV_AF] || (alarm_flag && !clear_c);
			summary_request_flag <= next_summary && !clear_c;
		end
	end

	// pin data answer, one cycle after read strobe
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			last_kind <= rtc_ctl_pkg::acc_read;
			data_out <= 8'h00;
			data_out_en <= 1'b0;
		end else begin
			last_kind <= bus_wr ? rtc_ctl_pkg::acc_write : rtc_ctl_pkg::acc_read;
			data_out <= bus_rd ? pin_rdata : 8'h00;
			data_out_en <= bus_rd;
		end
	end

	// software status, mask and readback
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			stat <= '0;
			mask <= '0;
			reg_rdata <= 8'h00;
			irq <= 1'b0;
			irq_n <= 1'b1;
			periodic_irq_enable <= 1'b0;
			alarm_irq_enable <= 1'b0;
			update_done_irq_enable <= 1'b0;
			square_wave_enable <= 1'b0;
		end else begin
			stat <= next_stat;
			if (mask_wr) begin
				mask <= reg_wdata[`RTC_EV_W-1:0];
			end
			reg_rdata <= reg_rd ? next_reg_rdata : 8'h00;
			irq <= |(next_stat & next_mask);
			irq_n <= !(next_summary && !clear_c && !restore_hold);
			periodic_irq_enable <= reg_b[`RTC_B_PIE] && !restore_hold;
			alarm_irq_enable <= reg_b[`RTC_B_AIE] && !restore_hold;
			update_done_irq_enable <= reg_b[`RTC_B_UIE] && !restore_hold;
			square_wave_enable <= reg_b[`RTC_B_SQW] && !restore_hold;
		end
	end

	property p_latch;
		@(posedge sys_clk) disable iff (sys_rst)
		(strobe_fall && pins_live) |=> latched_addr == $past(multiplexed_data_bus[ADDR_W-1:0]);
	endproperty
	a_latch: assert property (p_latch) else $error("address not latched");

	property p_hold;
		@(posedge sys_clk) disable iff (sys_rst)
		!(strobe_fall && pins_live) |=> $stable(latched_addr);
	endproperty
	a_hold: assert property (p_hold) else $error("address changed without strobe");

	property p_en_clr;
		@(posedge sys_clk) disable iff (sys_rst)
		restore_hold |=> !reg_b[`RTC_B_PIE] && !reg_b[`RTC_B_AIE] && !reg_b[`RTC_B_UIE];
	endproperty
	a_en_clr: assert property (p_en_clr) else $error("enables not cleared");

	property p_flag_clr;
		@(posedge sys_clk) disable iff (sys_rst)
		restore_hold |=> reg_c == 8'h00;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("flags not cleared");

	property p_sqw;
		@(posedge sys_clk) disable iff (sys_rst)
		restore_hold |=> !square_wave_enable;
	endproperty
	a_sqw: assert property (p_sqw) else $error("square wave not cleared");

	sequence s_blocked_read;
		data_read_strobe && restore_hold;
	endsequence
	property p_block;
		@(posedge sys_clk) disable iff (sys_rst)
		s_blocked_read |=> !data_out_en;
	endproperty
	a_block: assert property (p_block) else $error("access during restore");

	property p_pg;
		@(posedge sys_clk) disable iff (sys_rst)
		!power_good_in |=> !data_out_en && $stable(reg_a);
	endproperty
	a_pg: assert property (p_pg) else $error("pins live with power bad");

	property p_kind;
		@(posedge sys_clk) disable iff (sys_rst)
		(data_write_strobe && !pins_live) |=> last_kind == rtc_ctl_pkg::acc_read;
	endproperty
	a_kind: assert property (p_kind) else $error("write taken while pins isolated");

	property p_irq;
		@(posedge sys_clk) disable iff (sys_rst)
		irq == |(stat & mask);
	endproperty
	a_irq: assert property (p_irq) else $error("irq mismatch");
endmodule : rtc_bus_power_control

// >>> testbench/host_bus_model.sv
// host chipset model driving the clock section pins
`timescale 1ns/10ps
module host_bus_model (
	// clock
	input wire logic sys_clk,
	// pins
	output logic address_latch_strobe,
	output logic [7:0] multiplexed_data_bus,
	output logic data_read_strobe,
	output logic data_write_strobe
);
	initial begin
		address_latch_strobe = 1'b0;
		multiplexed_data_bus = 8'h00;
		data_read_strobe = 1'b0;
		data_write_strobe = 1'b0;
	end
	// address phase, bus held through the falling edge
	task latch(input logic [7:0] a);
		@(posedge sys_clk) address_latch_strobe <= 1'b1;
		multiplexed_data_bus <= a;
		@(posedge sys_clk) address_latch_strobe <= 1'b0;
	endtask : latch
	// data phase; released bus shows the inverse
	task access(input logic wr, input logic [7:0] d);
		@(posedge sys_clk) data_write_strobe <= wr;
		data_read_strobe <= !wr;
		multiplexed_data_bus <= wr ? d : ~multiplexed_data_bus;
		@(posedge sys_clk) data_write_strobe <= 1'b0;
		data_read_strobe <= 1'b0;
		multiplexed_data_bus <= ~multiplexed_data_bus;
	endtask : access
endmodule : host_bus_model

// >>> testbench/rtc_bus_power_control_bench.sv
// bench for the clock section power and bus front end
`timescale 1ns/10ps
module rtc_bus_power_control_bench;
	logic sys_clk = 0, sys_rst = 1, als, rds, wrs, rst_n = 1, pg = 1, test_in = 0;
	logic [7:0] bus, data_out, reg_wdata = 0, reg_rdata, d;
	logic data_out_en, irq_n, irq, reg_wr = 0, reg_rd = 0, rd_d = 0;
	wire [3:0] en;
	logic [2:0] ev = 0;
	logic [6:0] reg_addr = 0;
	logic [7:0] pin_q[$], sw_q[$];
	int failures = 0, comparisons = 0, cyc = 0;
	host_bus_model host_bus_model_i (.sys_clk(sys_clk), .address_latch_strobe(als), .multiplexed_data_bus(bus),
		.data_read_strobe(rds), .data_write_strobe(wrs));
	rtc_bus_power_control rtc_bus_power_control_i (.sys_clk(sys_clk), .sys_rst(sys_rst),
		.address_latch_strobe(als), .multiplexed_data_bus(bus), .data_read_strobe(rds),
		.data_write_strobe(wrs), .supply_restore_strobe_n(rst_n), .power_good_in(pg), .test_in(test_in),
		.data_out(data_out), .data_out_en(data_out_en), .core_event(ev), .periodic_irq_enable(en[3]),
		.alarm_irq_enable(en[2]), .update_done_irq_enable(en[1]), .square_wave_enable(en[0]),
		.irq_n(irq_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .irq(irq));
	initial begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	task chk(input string n, input logic [7:0] e, input logic [7:0] g);
		comparisons++;
		if (g !== e) begin
			failures++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task tick(input int n);
		repeat (n) @(posedge sys_clk);
	endtask : tick
	task pwr(input logic [7:0] a, input logic [7:0] v);
		host_bus_model_i.latch(a);
		host_bus_model_i.access(1'b1, v);
		tick(2);
	endtask : pwr
	task prd(input logic [7:0] a, input logic [7:0] e);
		pin_q.push_back(e);
		host_bus_model_i.latch(a);
		host_bus_model_i.access(1'b0, 8'h00);
		tick(1);
	endtask : prd
	task sw(input logic w, input logic [6:0] a, input logic [7:0] v);
		if (!w) sw_q.push_back(v);
		@(posedge sys_clk) reg_wr <= w;
		reg_rd <= !w;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge sys_clk) reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		tick(2);
	endtask : sw
	task pulse;
		@(posedge sys_clk) ev <= 3'h7;
		@(posedge sys_clk) ev <= 3'h0;
		tick(3);
	endtask : pulse
	task results;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : results
	// answers are matched against the oldest note
	always @(posedge sys_clk) begin
		rd_d <= reg_rd;
		if (data_out_en !== 1'b0) chk("data_out", pin_q.size() ? pin_q.pop_front() : 8'hxx, data_out);
		if (rd_d) chk("reg_rdata", sw_q.size() ? sw_q.pop_front() : 8'hxx, reg_rdata);
		cyc++;
		if (cyc == 3000) begin
			failures++;
			results();
		end
	end
	initial begin
		void'($urandom(37309));
		tick(16);
		sys_rst <= 1'b0;
		tick(2);
		chk("irq_n", 8'h01, {7'h0, irq_n});
		chk("enables", 8'h00, {4'h0, en});
		d = 8'($urandom) & 8'h78;
		pwr(8'h0b, d);
		tick(1);
		chk("enables", {4'h0, d[6:3]}, {4'h0, en});
		prd(8'h0b, d);
		pwr(8'h0a, d);
		prd(8'h0a, d);
		pwr(8'h2a, ~d);
		prd(8'h2a, ~d);
		prd(8'h0d, 8'h80);
		pin_q.push_back(8'h80);
		host_bus_model_i.access(1'b0, 8'h00);
		$display("test latch done");
		pg <= 1'b0;
		pwr(8'h0b, ~d);
		host_bus_model_i.access(1'b0, 8'h00);
		pg <= 1'b1;
		pin_q.push_back(8'h80);
		host_bus_model_i.access(1'b0, 8'h00);
		prd(8'h0b, d);
		$display("test power good done");
		pwr(8'h0b, 8'h78);
		test_in <= 1'b1;
		rst_n <= 1'b0;
		tick(3);
		chk("enables", 8'h0f, {4'h0, en});
		test_in <= 1'b0;
		tick(3);
		chk("enables", 8'h00, {4'h0, en});
		host_bus_model_i.latch(8'h0b);
		host_bus_model_i.access(1'b0, 8'h00);
		rst_n <= 1'b1;
		prd(8'h0b, 8'h00);
		$display("test restore done");
		pwr(8'h0b, 8'h70);
		pulse();
		chk("irq_n", 8'h00, {7'h0, irq_n});
		prd(8'h0c, 8'hf0);
		pulse();
		rst_n <= 1'b0;
		tick(3);
		rst_n <= 1'b1;
		prd(8'h0c, 8'h00);
		chk("irq_n", 8'h01, {7'h0, irq_n});
		$display("test flags done");
		sw(1'b1, 7'h7f, 8'h07);
		sw(1'b1, 7'h7e, 8'hff);
		chk("irq", 8'h00, {7'h0, irq});
		pulse();
		chk("irq", 8'h01, {7'h0, irq});
		sw(1'b0, 7'h7e, 8'h07);
		sw(1'b1, 7'h7e, 8'h02);
		sw(1'b0, 7'h7e, 8'h05);
		sw(1'b0, 7'h7f, 8'h07);
		sw(1'b0, 7'h10, 8'h00);
		sw(1'b1, 7'h7f, 8'h00);
		chk("irq", 8'h00, {7'h0, irq});
		$display("test status done");
		tick(4);
		chk("pending", 8'h00, 8'(pin_q.size() + sw_q.size()));
		results();
	end
endmodule : rtc_bus_power_control_bench
